// File: src/dtt_timer.sv
// Functional notes
// - mode bit zero is transmit, else demodulation
// - transmit: select bit routes combined output pin
// - demod: select bit picks alternate or comparator input
// - comparator-input capture also pulses port edge irq
// - long one-shot ignores unarmed edges; short timeout captures
// - setting one-shot bit from zero arms one capture-reload edge
// - long zero wraps, sets timeout flag, irq
// - ping-pong short start: initial level, matching reload
// - short end hands over to long with reload
// - long end hands back to short, forever
// - each terminal count irq when enabled
// - hardware alternates enable bits in ping-pong
// - timeout flag set at every terminal count
// - short output drives its pin when enabled
// - long output drives its pin when enabled
// - combined pin shows chosen logic combination
// - initial bits give starting output levels
`timescale 1ns/1ps
`default_nettype none
module dtt_timer
    import dtt_pkg::*;
(
    input wire logic i_ref_clk,                  // 50 MHz timer clock
    input wire logic i_rst,                      // sync reset, high
    input wire logic [5:0] i_avs_address,        // byte address
    input wire logic i_avs_read,                 // read request
    input wire logic i_avs_write,                // write request
    input wire logic [31:0] i_avs_writedata,     // write data
    input wire logic [3:0] i_avs_byteenable,     // byte lanes
    output logic [31:0] o_avs_readdata,          // read data
    output logic o_avs_waitrequest,              // stall request
    input wire logic i_alt_demod_input_pin,      // demod input a
    input wire logic i_comparator_demod_input_pin, // demod input b
    output logic o_short_out_pin,                // short timer pin
    output logic o_long_out_pin,                 // long timer pin
    output logic o_combined_output_pin,          // combined pin
    output logic o_short_irq,                    // short tc request
    output logic o_long_irq,                     // long tc/capture req
    output logic o_port_edge_irq                 // capture via cmp pin
);
    // ********
    // bus slave
    // ********
    logic [5:0] adr;
    logic wait_r;
    logic [31:0] rdata_r;
    logic req;
    logic wr_acc;
    logic [7:0] wd;
    logic wr_sctl, wr_cctl, wr_lctl;
    logic wr_shi, wr_slo, wr_lhi, wr_llo, wr_port;
    logic [7:0] rd_byte;

    // ********
    // register state
    // ********
    dtt_short_ctrl_t sctl_r, sctl_nxt;
    dtt_shared_ctrl_t cctl_r, cctl_nxt;
    dtt_long_ctrl_t lctl_r, lctl_nxt;
    logic [7:0] short_high_reload_r, short_low_reload_r;
    logic [7:0] long_reload_high_r, long_reload_low_r;
    logic [2:0] port_out_r;
    logic [15:0] capt_r;
    logic arm_r;
    logic in_prev_r;
    logic short_out_r, long_out_r;
    logic short_out_nxt, long_out_nxt;
    logic s_irq_r, l_irq_r, pe_irq_r;

    // ********
    // timer datapath
    // ********
    logic xmit, demod, pp;
    logic [7:0] s_cnt;
    logic [15:0] l_cnt;
    logic s_tc, l_tc;
    logic s_start, l_start;
    logic s_load, l_load;
    logic [7:0] s_load_val;
    logic demod_in, rise, fall, edge_hit;
    logic cap_edge, cap_tout, cap_ev;
    dtt_pins_t pins;

    // one wait cycle on every access keeps read data registered
    assign adr = i_avs_address;
    assign req = i_avs_read | i_avs_write;
    assign wr_acc = i_avs_write & ~wait_r & i_avs_byteenable[0];
    assign wd = i_avs_writedata[7:0];
    assign wr_sctl = wr_acc & (adr == ADR_SHORT_CTRL);
    assign wr_cctl = wr_acc & (adr == ADR_SHARED_CTRL);
    assign wr_lctl = wr_acc & (adr == ADR_LONG_CTRL);
    assign wr_shi = wr_acc & (adr == ADR_SHORT_HI);
    assign wr_slo = wr_acc & (adr == ADR_SHORT_LO);
    assign wr_lhi = wr_acc & (adr == ADR_LONG_HI);
    assign wr_llo = wr_acc & (adr == ADR_LONG_LO);
    assign wr_port = wr_acc & (adr == ADR_PORT_OUT);

    // read decode; unmapped words read as zero
    assign rd_byte =
        (adr == ADR_SHORT_CTRL) ? sctl_r :
        (adr == ADR_SHARED_CTRL) ? cctl_r :
        (adr == ADR_LONG_CTRL) ? lctl_r :
        (adr == ADR_SHORT_HI) ? short_high_reload_r :
        (adr == ADR_SHORT_LO) ? short_low_reload_r :
        (adr == ADR_LONG_HI) ? long_reload_high_r :
        (adr == ADR_LONG_LO) ? long_reload_low_r :
        (adr == ADR_CAPT_HI) ? capt_r[15:8] :
        (adr == ADR_CAPT_LO) ? capt_r[7:0] :
        (adr == ADR_PORT_OUT) ? {5'h00, port_out_r} : 8'h00;

    // bus handshake registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~(req & wait_r);
            if (i_avs_read & wait_r) begin
                rdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ********
    // mode decode
    // ********
    assign demod = cctl_r.mode;
    assign xmit = ~demod;
    // ping-pong is honoured only in transmit
    assign pp = xmit & (cctl_r.sub == SUB_PINGPONG);

    // ********
    // short timer
    // ********
    // a start is software raising enable, or the long timer handing back
    assign s_start = (wr_sctl & wd[7] & ~sctl_r.en) |
                     (pp & l_tc);
    // start takes the initial level, each tc toggles the level
    assign short_out_nxt = s_start ? cctl_r.init_short :
                           (s_tc ? ~short_out_r : short_out_r);
    // reload follows the level the output is about to take
    assign s_load_val = short_out_nxt ? short_high_reload_r :
                        short_low_reload_r;
    assign s_load = s_start | s_tc;

    dtt_down_counter #(.W(8)) u_short_cnt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(s_load),
        .i_load_val(s_load_val),
        .i_run(sctl_r.en),
        .o_count(s_cnt),
        .o_tc(s_tc)
    );

    // ********
    // long timer and demodulation input
    // ********
    assign l_start = (wr_lctl & wd[7] & ~lctl_r.en) |
                     (pp & s_tc);
    // plain transmit may force the long level through the submode
    assign long_out_nxt = (xmit & l_start) ? cctl_r.init_long :
                          ((xmit & l_tc) ? ~long_out_r : long_out_r);

    assign demod_in = cctl_r.comb_sel ? i_comparator_demod_input_pin :
                      i_alt_demod_input_pin;
    assign rise = demod_in & ~in_prev_r;
    assign fall = ~demod_in & in_prev_r;
    assign edge_hit = (cctl_r.func == EDGE_FALL) ? fall :
                      (cctl_r.func == EDGE_RISE) ? rise :
                      (rise | fall);

    // one-shot bit set: only an armed edge counts
    assign cap_edge = demod & lctl_r.en & edge_hit &
                      (~lctl_r.single | arm_r);
    // one-shot: short timeout captures without reload
    assign cap_tout = demod & lctl_r.en & lctl_r.single & s_tc;
    assign cap_ev = cap_edge | cap_tout;
    // in demod a zero count simply wraps to all ones, no load
    assign l_load = (xmit & (l_start | l_tc)) |
                    (demod & (cap_edge | l_start));

    dtt_down_counter #(.W(16)) u_long_cnt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(l_load),
        .i_load_val({long_reload_high_r, long_reload_low_r}),
        .i_run(lctl_r.en),
        .o_count(l_cnt),
        .o_tc(l_tc)
    );

    // ********
    // control register updates
    // ********
    // software write first, hardware events override after it
    always_comb begin
        sctl_nxt = sctl_r;
        cctl_nxt = cctl_r;
        lctl_nxt = lctl_r;
        if (wr_sctl) begin
            sctl_nxt = wd;
            sctl_nxt.rsv = 3'h0;
            sctl_nxt.tout = sctl_r.tout;
        end
        if (wr_cctl) begin
            cctl_nxt = wd;
            if (demod) begin
                cctl_nxt.init_short = cctl_r.init_short;
                cctl_nxt.init_long = cctl_r.init_long;
            end
        end
        if (wr_lctl) begin
            lctl_nxt = wd;
            lctl_nxt.rsv = 2'h0;
            lctl_nxt.tout = lctl_r.tout;
        end
        // timeout flags: write one clears, a same-cycle tc wins
        sctl_nxt.tout = dtt_flag(sctl_r.tout, s_tc,
                                 wr_sctl & wd[5]);
        lctl_nxt.tout = dtt_flag(lctl_r.tout, l_tc,
                                 wr_lctl & wd[5]);
        // demod edge flags share the initial-level bits
        if (demod) begin
            cctl_nxt.init_short = dtt_flag(cctl_r.init_short, rise,
                                           wr_cctl & wd[1]);
            cctl_nxt.init_long = dtt_flag(cctl_r.init_long, fall,
                                          wr_cctl & wd[0]);
        end
        // single-pass stops at its tc in plain transmit only
        if (xmit & ~pp & s_tc & sctl_r.single) begin
            sctl_nxt.en = 1'b0;
        end
        if (xmit & ~pp & l_tc & lctl_r.single) begin
            lctl_nxt.en = 1'b0;
        end
        // ping-pong alternates the enables with no software help
        if (pp & s_tc) begin
            sctl_nxt.en = 1'b0;
            lctl_nxt.en = 1'b1;
        end
        if (pp & l_tc) begin
            lctl_nxt.en = 1'b0;
            sctl_nxt.en = 1'b1;
        end
    end

    // control, reload and port registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sctl_r <= RST_CTRL;
            cctl_r <= RST_CTRL;
            lctl_r <= RST_CTRL;
            short_high_reload_r <= RST_RELOAD;
            short_low_reload_r <= RST_RELOAD;
            long_reload_high_r <= RST_RELOAD;
            long_reload_low_r <= RST_RELOAD;
            port_out_r <= RST_PORT;
        end else begin
            sctl_r <= sctl_nxt;
            cctl_r <= cctl_nxt;
            lctl_r <= lctl_nxt;
            if (wr_shi) short_high_reload_r <= wd;
            if (wr_slo) short_low_reload_r <= wd;
            if (wr_lhi) long_reload_high_r <= wd;
            if (wr_llo) long_reload_low_r <= wd;
            if (wr_port) port_out_r <= wd[2:0];
        end
    end

    // ********
    // capture, arming and timer output levels
    // ********
    // arming needs the one-shot bit to go from zero to one
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            arm_r <= 1'b0;
            in_prev_r <= 1'b0;
            capt_r <= RST_CAPT;
            short_out_r <= 1'b0;
            long_out_r <= 1'b0;
        end else begin
            in_prev_r <= demod_in;
            if (wr_lctl & wd[6] & ~lctl_r.single) begin
                arm_r <= 1'b1;
            end else if (cap_edge) begin
                arm_r <= 1'b0;
            end
            if (cap_ev) begin
                capt_r <= l_cnt;
            end
            short_out_r <= short_out_nxt;
            long_out_r <= long_out_nxt;
        end
    end

    // ********
    // interrupt request pulses toward the system controller
    // ********
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_irq_r <= 1'b0;
            l_irq_r <= 1'b0;
            pe_irq_r <= 1'b0;
        end else begin
            s_irq_r <= s_tc & sctl_r.irq_en;
            l_irq_r <= (l_tc & lctl_r.tout_irq_en) |
                       (cap_ev & lctl_r.cap_irq_en);
            // masking is the system controller's job
            pe_irq_r <= cap_ev & cctl_r.comb_sel;
        end
    end

    // ********
    // pins
    // ********
    dtt_pin_out u_pins (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_xmit(xmit),
        .i_short_pin_en(sctl_r.pin_en),
        .i_long_pin_en(lctl_r.pin_en),
        .i_comb_sel(cctl_r.comb_sel),
        .i_func(cctl_r.func),
        .i_short_lvl(short_out_r),
        .i_long_lvl((xmit & ~pp & cctl_r.sub[1]) ? cctl_r.sub[0] :
                    long_out_r),
        .i_port_out(port_out_r),
        .o_pins(pins)
    );

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_short_out_pin = pins.short_pin;
    assign o_long_out_pin = pins.long_pin;
    assign o_combined_output_pin = pins.comb;
    assign o_short_irq = s_irq_r;
    assign o_long_irq = l_irq_r;
    assign o_port_edge_irq = pe_irq_r;
endmodule
`default_nettype wire

// File: src/dtt_pkg.sv
package dtt_pkg;

    // ********
    // register map, byte addresses of 32-bit words
    // ********
    localparam logic [5:0] ADR_SHORT_CTRL = 6'h00;
    localparam logic [5:0] ADR_SHARED_CTRL = 6'h04;
    localparam logic [5:0] ADR_LONG_CTRL = 6'h08;
    localparam logic [5:0] ADR_SHORT_HI = 6'h0C;
    localparam logic [5:0] ADR_SHORT_LO = 6'h10;
    localparam logic [5:0] ADR_LONG_HI = 6'h14;
    localparam logic [5:0] ADR_LONG_LO = 6'h18;
    localparam logic [5:0] ADR_CAPT_HI = 6'h1C;
    localparam logic [5:0] ADR_CAPT_LO = 6'h20;
    localparam logic [5:0] ADR_PORT_OUT = 6'h24;

    // ********
    // reset values
    // ********
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [2:0] RST_PORT = 3'h0;
    localparam logic [15:0] RST_CAPT = 16'h0000;

    // ********
    // field codes
    // ********
    // transmit submode, shared ctrl bits 3:2
    localparam logic [1:0] SUB_NORMAL = 2'h0;
    localparam logic [1:0] SUB_PINGPONG = 2'h1;
    // demod edge select, shared ctrl bits 5:4
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    // transmit combine function, shared ctrl bits 5:4
    localparam logic [1:0] FN_AND = 2'h0;
    localparam logic [1:0] FN_OR = 2'h1;
    localparam logic [1:0] FN_NOR = 2'h2;
    // port_out bit positions for the three pins
    localparam int unsigned PO_SHORT = 0;
    localparam int unsigned PO_LONG = 1;
    localparam int unsigned PO_COMB = 2;

    // ********
    // control register layouts, bit 7 first
    // ********
    typedef struct packed {
        logic en;
        logic single;
        logic tout;
        logic [2:0] rsv;
        logic irq_en;
        logic pin_en;
    } dtt_short_ctrl_t;

    typedef struct packed {
        logic mode;
        logic comb_sel;
        logic [1:0] func;
        logic [1:0] sub;
        logic init_short;
        logic init_long;
    } dtt_shared_ctrl_t;

    typedef struct packed {
        logic en;
        logic single;
        logic tout;
        logic [1:0] rsv;
        logic cap_irq_en;
        logic tout_irq_en;
        logic pin_en;
    } dtt_long_ctrl_t;

    // pin levels leaving the block
    typedef struct packed {
        logic comb;
        logic long_pin;
        logic short_pin;
    } dtt_pins_t;

    // hardware-set flag, set wins over a software clear
    function automatic logic dtt_flag(input logic cur, input logic set,
                                      input logic clr);
        dtt_flag = set | (cur & ~clr);
    endfunction

endpackage

// File: src/dtt_down_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dtt_down_counter #(
    parameter int unsigned W = 8
) (
    input wire logic i_ref_clk,         // timer clock
    input wire logic i_rst,             // sync reset, active high
    input wire logic i_load,            // load i_load_val this edge
    input wire logic [W-1:0] i_load_val, // reload value
    input wire logic i_run,             // count enable
    output logic [W-1:0] o_count,       // current count
    output logic o_tc                   // terminal count this cycle
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // load beats counting; zero minus one wraps to all ones
    assign count_nxt = i_load ? i_load_val :
                       (i_run ? count_r - {{(W-1){1'b0}}, 1'b1} : count_r);
    assign o_tc = i_run & (count_r == '0);
    assign o_count = count_r;

    // count register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule
`default_nettype wire

// File: src/dtt_pin_out.sv
`timescale 1ns/1ps
`default_nettype none
module dtt_pin_out
    import dtt_pkg::*;
(
    input wire logic i_ref_clk,          // timer clock
    input wire logic i_rst,              // sync reset, active high
    input wire logic i_xmit,             // transmit mode
    input wire logic i_short_pin_en,     // short output to its pin
    input wire logic i_long_pin_en,      // long output to its pin
    input wire logic i_comb_sel,         // combined output enable
    input wire logic [1:0] i_func,       // combine function
    input wire logic i_short_lvl,        // short_timer_output
    input wire logic i_long_lvl,         // long_timer_output
    input wire logic [2:0] i_port_out,   // plain port levels
    output dtt_pins_t o_pins             // registered pin levels
);
    logic combo;
    dtt_pins_t pins_nxt;
    dtt_pins_t pins_r;

    // combine function of the two timer outputs
    assign combo = (i_func == FN_AND) ? (i_short_lvl & i_long_lvl) :
                   (i_func == FN_OR) ? (i_short_lvl | i_long_lvl) :
                   (i_func == FN_NOR) ? ~(i_short_lvl | i_long_lvl) :
                   (i_short_lvl ^ i_long_lvl);

    // each pin falls back to its port level when not claimed
    assign pins_nxt.short_pin = i_short_pin_en ? i_short_lvl :
                                i_port_out[PO_SHORT];
    assign pins_nxt.long_pin = i_long_pin_en ? i_long_lvl :
                               i_port_out[PO_LONG];
    // in demod the select bit picks the input, so the pin stays plain
    assign pins_nxt.comb = (i_xmit & i_comb_sel) ? combo :
                           i_port_out[PO_COMB];
    assign o_pins = pins_r;

    // pin registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pins_r <= '0;
        end else begin
            pins_r <= pins_nxt;
        end
    end
endmodule
`default_nettype wire

// File: verification/dtt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// demod input pins, far side
// ********
module dtt_pin_model (
    input wire logic i_ref_clk, // timer clock
    input wire logic i_go,      // toggle the chosen pin
    input wire logic i_sel,     // 1 comparator, 0 alternate
    output logic o_alt,         // alternate input pin
    output logic o_cmp          // comparator input pin
);
    // level inputs: a held level is the honest idle state
    initial begin
        o_alt = 1'b0;
        o_cmp = 1'b0;
    end
    always @(posedge i_ref_clk) begin
        if (i_go && i_sel) o_cmp <= ~o_cmp;
        if (i_go && !i_sel) o_alt <= ~o_alt;
    end
endmodule
`default_nettype wire

// File: verification/dtt_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bus and reset checks
// ********
module dtt_timer_checker (
    input wire logic i_ref_clk,             // timer clock
    input wire logic i_rst,                 // sync reset
    input wire logic i_avs_read,            // read request
    input wire logic i_avs_write,           // write request
    input wire logic [31:0] o_avs_readdata, // read data
    input wire logic o_avs_waitrequest,     // stall
    input wire logic o_short_out_pin,       // short pin
    input wire logic o_long_out_pin,        // long pin
    input wire logic o_combined_output_pin, // combined pin
    input wire logic o_short_irq,           // short request
    input wire logic o_long_irq,            // long request
    input wire logic o_port_edge_irq        // edge request
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // one request line, read and write never overlap
    logic req;
    assign req = i_avs_read | i_avs_write;
    sequence s_accept;
        req && !o_avs_waitrequest;
    endsequence
    a_req_answer: assert property ($rose(req) |=> !o_avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_needs_req: assert property (!o_avs_waitrequest |-> req && $past(req))
        else $error("answer without request");
    a_idle_wait: assert property (!req |=> o_avs_waitrequest)
        else $error("waitrequest low while idle");
    a_back_to_back: assert property (s_accept ##1 req |=> !o_avs_waitrequest)
        else $error("back to back request stalled");
    a_rd_upper: assert property (o_avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_rd_stands: assert property ($changed(o_avs_readdata) |->
        !o_avs_waitrequest && i_avs_read)
        else $error("read data moved outside a read");
    a_reset_quiet: assert property ($fell(i_rst) |-> o_avs_waitrequest &&
        o_avs_readdata == 32'h00000000 && !o_short_out_pin &&
        !o_long_out_pin && !o_combined_output_pin && !o_short_irq &&
        !o_long_irq && !o_port_edge_irq)
        else $error("outputs not quiet after reset");
endmodule
bind dtt_timer dtt_timer_checker u_dtt_timer_checker (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_short_out_pin(o_short_out_pin), .o_long_out_pin(o_long_out_pin),
    .o_combined_output_pin(o_combined_output_pin),
    .o_short_irq(o_short_irq), .o_long_irq(o_long_irq),
    .o_port_edge_irq(o_port_edge_irq));
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import dtt_pkg::*;
;
    typedef struct {string nm; logic [7:0] v;} dtt_note_t;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0;
    logic sel = 1'b0, ob_v = 1'b0, wq, alt, cmp, p_s, p_l, p_c;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, lf = 32'hD6598E56;
    logic [7:0] ob = 8'h00, s;
    logic [3:0] c4;
    logic [2:0] irq;
    int n_mismatch = 0, checked = 0, cyc = 0, n_pe = 0, f, k;
    dtt_note_t q[$];
    dtt_timer u_dtt_timer (.i_ref_clk(clk), .i_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_alt_demod_input_pin(alt),
        .i_comparator_demod_input_pin(cmp), .o_short_out_pin(p_s),
        .o_long_out_pin(p_l), .o_combined_output_pin(p_c),
        .o_short_irq(irq[0]), .o_long_irq(irq[1]), .o_port_edge_irq(irq[2]));
    dtt_pin_model u_dtt_pin_model (.i_ref_clk(clk), .i_go(go), .i_sel(sel),
        .o_alt(alt), .o_cmp(cmp));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
    endfunction
    // request held until waitrequest low; only the bench timeout ends it
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        adr <= a;
        rd <= ~w;
        wr <= w;
        wd <= {24'h000000, d};
        do @(posedge clk); while (wq !== 1'b0);
    endtask
    task automatic rel;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string t, input logic [5:0] a, input logic [7:0] e);
        q.push_back('{t, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic chk(input string t, input logic [7:0] e, input logic [7:0] v);
        q.push_back('{t, e});
        ob <= v;
        ob_v <= 1'b1;
        @(posedge clk);
        ob_v <= 1'b0;
        @(posedge clk);
    endtask
    // poll a request line; a pulse stands one cycle so every edge counts
    task automatic wt(input int b, output logic [7:0] seen);
        seen = 8'h00;
        for (int i = 0; i < 600 && seen == 8'h00; i++) begin
            @(posedge clk);
            if (irq[b] === 1'b1) seen = 8'h01;
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // monitor: oldest note against each read answer or pin sample
    always @(posedge clk) begin
        dtt_note_t e;
        logic [7:0] got;
        if ((rd === 1'b1 && wq === 1'b0) || ob_v === 1'b1) begin
            e = q.pop_front();
            got = ob_v ? ob : rdat[7:0];
            checked++;
            if (got !== e.v) begin
                n_mismatch++;
                $display("Error %s expected %h seen %h", e.nm, e.v, got);
            end
        end
    end
    // edge request count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq[2] === 1'b1) n_pe <= n_pe + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("short ctrl", ADR_SHORT_CTRL, RST_CTRL);
        rdc("shared ctrl", ADR_SHARED_CTRL, RST_CTRL);
        rdc("long ctrl", ADR_LONG_CTRL, RST_CTRL);
        rdc("capture hi", ADR_CAPT_HI, RST_CAPT[15:8]);
        rdc("unmapped", 6'h3C, 8'h00);
        lf = lfsr_step(lf);
        bus(1'b1, ADR_PORT_OUT, {5'h00, lf[2:0]});
        rel();
        repeat (3) @(posedge clk);
        chk("port pins", {5'h00, lf[2:0]}, {5'h00, p_c, p_l, p_s});
        $display("test reset and port done");
        // all-ones short reloads and a 0xFF00 long reload hold the start levels
        bus(1'b1, ADR_SHORT_HI, 8'hFF);
        bus(1'b1, ADR_SHORT_LO, 8'hFF);
        bus(1'b1, ADR_LONG_HI, 8'hFF);
        for (f = 0; f < 4; f++) begin
            lf = lfsr_step(lf);
            c4 = {lf[1] ^ lf[0], ~(lf[1] | lf[0]), lf[1] | lf[0], lf[1] & lf[0]};
            bus(1'b1, ADR_SHORT_CTRL, 8'h00);
            bus(1'b1, ADR_LONG_CTRL, 8'h00);
            bus(1'b1, ADR_SHARED_CTRL, {2'b01, f[1:0], 2'b00, lf[1:0]});
            bus(1'b1, ADR_SHORT_CTRL, 8'h81);
            bus(1'b1, ADR_LONG_CTRL, 8'h81);
            rel();
            repeat (3) @(posedge clk);
            chk("comb pins", {5'h00, c4[f], lf[0], lf[1]}, {5'h00, p_c, p_l, p_s});
        end
        $display("test combine done");
        bus(1'b1, ADR_LONG_CTRL, 8'h00);
        bus(1'b1, ADR_SHARED_CTRL, 8'h00);
        bus(1'b1, ADR_SHORT_CTRL, 8'h00);
        bus(1'b1, ADR_SHORT_LO, 8'h40);
        bus(1'b1, ADR_SHORT_CTRL, 8'h83);
        rel();
        wt(0, s);
        chk("short irq", 8'h01, s);
        rdc("short tout", ADR_SHORT_CTRL, 8'hA3);
        bus(1'b1, ADR_SHORT_CTRL, 8'hA3);
        rdc("short clear", ADR_SHORT_CTRL, 8'h83);
        rel();
        chk("short pin", 8'h01, {7'h00, p_s});
        $display("test short count done");
        bus(1'b1, ADR_SHORT_CTRL, 8'h20);
        bus(1'b1, ADR_LONG_CTRL, 8'h20);
        bus(1'b1, ADR_SHARED_CTRL, 8'h06);
        bus(1'b1, ADR_SHORT_HI, 8'h10);
        bus(1'b1, ADR_LONG_HI, 8'h00);
        bus(1'b1, ADR_LONG_LO, 8'h20);
        bus(1'b1, ADR_LONG_CTRL, 8'h42);
        bus(1'b1, ADR_SHORT_CTRL, 8'hC2);
        rel();
        wt(0, s);
        chk("pp short irq", 8'h01, s);
        rdc("pp short off", ADR_SHORT_CTRL, 8'h62);
        rdc("pp long on", ADR_LONG_CTRL, 8'hC2);
        rel();
        wt(1, s);
        chk("pp long irq", 8'h01, s);
        rdc("pp short on", ADR_SHORT_CTRL, 8'hE2);
        rdc("pp long off", ADR_LONG_CTRL, 8'h62);
        rel();
        wt(0, s);
        chk("pp again", 8'h01, s);
        bus(1'b1, ADR_SHARED_CTRL, 8'h00);
        bus(1'b1, ADR_SHORT_CTRL, 8'h20);
        bus(1'b1, ADR_LONG_CTRL, 8'h20);
        $display("test ping-pong done");
        bus(1'b1, ADR_LONG_LO, 8'h60);
        bus(1'b1, ADR_SHARED_CTRL, 8'hE0);
        bus(1'b1, ADR_LONG_CTRL, 8'h80);
        bus(1'b1, ADR_LONG_CTRL, 8'hC6);
        rel();
        for (f = 0; f < 2; f++) begin
            k = n_pe;
            sel <= 1'b1;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (10) @(posedge clk);
            chk("port irq", f == 0, 8'(n_pe - k));
        end
        wt(1, s);
        rdc("long wrap", ADR_LONG_CTRL, 8'hE6);
        bus(1'b1, ADR_SHARED_CTRL, 8'hA0);
        bus(1'b1, ADR_LONG_CTRL, 8'h80);
        bus(1'b1, ADR_LONG_CTRL, 8'hC4);
        rel();
        k = n_pe;
        sel <= 1'b0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wt(1, s);
        chk("alt capture", 8'h01, s);
        chk("alt no edge irq", 8'h00, 8'(n_pe - k));
        $display("test demod done");
        report_and_stop();
    end
endmodule
`default_nettype wire
